// [verilog/fsvf_top.sv]
// Purpose: Underspeed V/f limiter, overspeed, short-circuit timer and underexcitation watch.
// Assumes: One measurement sample per i_sample_valid pulse; inputs synchronous to i_clk.
// Notes:   Parameter locations are written and read on a simple indexed port.
// How it works
// (RQ1) Underspeed value 26214 trips at 48 Hz, or 57.5 Hz in sixty-hertz mode.
// (RQ2) Values 0 to 26214 interpolate linearly from 40/48 Hz upward.
// (RQ3) Values 26214 to 32767 rise linearly to 50 Hz or 60 Hz.
// (RQ4) Sixty-hertz mode from enabled closed jumper or configuration flag.
// (RQ5) Below trip point voltage follows frequency and underspeed alarm is raised.
// (RQ6) Enabled trimmer replaces parameter; effective threshold is readable.
// (RQ7) Working slope defaults 1875; bigger drops more, zero drops nothing.
// (RQ8) Above trip point normal voltage returns and underspeed alarm clears.
// (RQ9) Overspeed value zero trips at 55 Hz or 66 Hz.
// (RQ10) Negative overspeed values lower the trip linearly to 50/60 Hz.
// (RQ11) Positive overspeed values raise the trip linearly to 60/72 Hz.
// (RQ12) Voltage floor from supply-ratio coefficient keeps supply sufficient.
// (RQ13) Start-up slope 1250 applies until frequency first passes the threshold.
// (RQ14) Short circuit counted in tenths, blocking at expiry; zero disables.
// (RQ15) Underexcitation alarm when excitation above fixed upper or below lower limit.
// (RQ16) Upper excitation limit fixed; only lower limit programmable.
// (RQ17) Underexcitation only signals and drives the configured alarm contact.
// (RQ18) Active alarms one-hot in status word; healthy bit when none.
// (RQ19) Every comparison re-evaluated per sample, no hysteresis, current parameters.
// (RQ20) Blocked state holds until device reset.
`timescale 1ns/1ps
`default_nettype none
module fsvf_top #(
  parameter int unsigned TENTH_CYCLES = fsvf_pkg::TENTH_S_CYC
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire fsvf_pkg::fsvf_wr_t   i_wr,
  input  wire logic [7:0]           i_rd_addr,
  input  wire logic                 i_sample_valid,
  input  wire fsvf_pkg::fsvf_sample_t i_sample,
  input  wire logic [15:0]          i_vref_nominal,
  input  wire logic                 i_frequency_trimmer_en,
  input  wire logic [15:0]          i_frequency_trimmer_input,
  input  wire logic                 i_jumper_closed,
  input  wire logic                 i_jumper_use_en,
  input  wire logic                 i_cfg_sixty_hz,
  input  wire logic                 i_short_circuit,
  input  wire logic                 i_alarm_contact_en,
  output logic [15:0]               o_rd_data,
  output logic [15:0]               o_vref,
  output logic [15:0]               o_status,
  output logic                      o_blocked,
  output logic                      o_alarm_output_contact
);
  if (TENTH_CYCLES < 1) begin : g_bad_tenth
    $error("TENTH_CYCLES must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Parameter store.
  logic [15:0] supply_ratio_coeff;
  logic [15:0] underspeed_threshold_param;
  logic [15:0] working_vf_slope;
  logic [15:0] startup_vf_slope;
  logic [15:0] short_circuit_time;
  logic [15:0] overspeed_threshold_param;
  logic [15:0] underexcite_low_limit;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      supply_ratio_coeff         <= fsvf_pkg::RST_SUPPLY_RATIO;
      underspeed_threshold_param <= fsvf_pkg::RST_UNDERSPEED;
      working_vf_slope           <= fsvf_pkg::RST_WORK_SLOPE;
      startup_vf_slope           <= fsvf_pkg::RST_START_SLOPE;
      short_circuit_time         <= fsvf_pkg::RST_SC_TIME;
      overspeed_threshold_param  <= fsvf_pkg::RST_OVERSPEED;
      underexcite_low_limit      <= fsvf_pkg::RST_EXC_LOW;
    end else if (i_wr.wr) begin
      // (RQ16) lower limit writable
      // The upper excitation limit has no location, so writes cannot reach it.
      case (i_wr.addr)
        fsvf_pkg::ADDR_SUPPLY_RATIO: supply_ratio_coeff         <= i_wr.data;
        fsvf_pkg::ADDR_UNDERSPEED:   underspeed_threshold_param <= i_wr.data;
        fsvf_pkg::ADDR_WORK_SLOPE:   working_vf_slope           <= i_wr.data;
        fsvf_pkg::ADDR_START_SLOPE:  startup_vf_slope           <= i_wr.data;
        fsvf_pkg::ADDR_SC_TIME:      short_circuit_time         <= i_wr.data;
        fsvf_pkg::ADDR_OVERSPEED:    overspeed_threshold_param  <= i_wr.data;
        fsvf_pkg::ADDR_EXC_LOW:      underexcite_low_limit      <= i_wr.data;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Trip points.
  // (RQ4) sixty-hertz select
  wire logic sixty = (i_jumper_closed & i_jumper_use_en) | i_cfg_sixty_hz;
  // (RQ6) trimmer overrides parameter
  wire logic [15:0] us_raw = i_frequency_trimmer_en ? i_frequency_trimmer_input : underspeed_threshold_param;
  // Values above full scale are clamped so the upper segment never overshoots.
  wire logic [15:0] us_val = (us_raw > fsvf_pkg::FULL_SCALE) ? fsvf_pkg::FULL_SCALE : us_raw;
  wire logic        us_upper = us_val > fsvf_pkg::US_KNEE;

  wire logic [15:0] us_low  = sixty ? fsvf_pkg::US_LOW_60  : fsvf_pkg::US_LOW_50;
  wire logic [15:0] us_knee = sixty ? fsvf_pkg::US_KNEE_60 : fsvf_pkg::US_KNEE_50;
  wire logic [15:0] us_top  = sixty ? fsvf_pkg::US_TOP_60  : fsvf_pkg::US_TOP_50;

  // (RQ1) knee at 48 or 57.5 Hz
  // (RQ2) lower segment from 40 or 48 Hz
  // (RQ3) upper segment to 50 or 60 Hz
  wire logic signed [16:0] us_base = us_upper ? $signed({1'b0, us_knee}) : $signed({1'b0, us_low});
  wire logic signed [16:0] us_x    = us_upper ? $signed({1'b0, us_val - fsvf_pkg::US_KNEE})
                                              : $signed({1'b0, us_val});
  wire logic signed [16:0] us_span = us_upper ? $signed({1'b0, us_top - us_knee})
                                              : $signed({1'b0, us_knee - us_low});
  wire logic signed [16:0] us_den  = us_upper ? $signed({1'b0, fsvf_pkg::US_TOP_SPAN})
                                              : $signed({1'b0, fsvf_pkg::US_KNEE});
  logic signed [16:0] us_trip;
  fsvf_lerp #(.W(16)) u_us_lerp (
    .i_base (us_base),
    .i_x    (us_x),
    .i_span (us_span),
    .i_den  (us_den),
    .o_val  (us_trip)
  );

  // (RQ9) zero gives 55 or 66 Hz
  // (RQ10) signed, negative lowers
  // (RQ11) positive raises to 60 or 72 Hz
  wire logic signed [16:0] os_base = sixty ? $signed({1'b0, fsvf_pkg::OS_MID_60})
                                           : $signed({1'b0, fsvf_pkg::OS_MID_50});
  wire logic signed [16:0] os_span = sixty ? $signed({1'b0, fsvf_pkg::OS_SPAN_60})
                                           : $signed({1'b0, fsvf_pkg::OS_SPAN_50});
  wire logic signed [16:0] os_x    = $signed({overspeed_threshold_param[15], overspeed_threshold_param});
  logic signed [16:0] os_trip;
  fsvf_lerp #(.W(16)) u_os_lerp (
    .i_base (os_base),
    .i_x    (os_x),
    .i_span (os_span),
    .i_den  ($signed({1'b0, fsvf_pkg::FULL_SCALE})),
    .o_val  (os_trip)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Per-sample comparisons.
  // (RQ19) evaluated each sample
  wire logic [15:0] us_thr     = us_trip[15:0];
  wire logic [15:0] freq       = i_sample.freq;
  wire logic        next_under = freq < us_thr;
  wire logic        next_over  = $signed({1'b0, freq}) > os_trip;
  // (RQ15) window compare
  wire logic        next_unexc = (i_sample.excite > fsvf_pkg::EXC_UPPER_LIMIT) ||
                                 (i_sample.excite < underexcite_low_limit);

  logic        underspeed;
  logic        overspeed;
  logic        underexcite;
  logic        started;
  logic [15:0] eff_us;
  logic [15:0] exc_value;
  logic [15:0] sample_freq;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      underspeed  <= 1'b0;
      overspeed   <= 1'b0;
      underexcite <= 1'b0;
      started     <= 1'b0;
      eff_us      <= 16'h0000;
      exc_value   <= 16'h0000;
      sample_freq <= 16'h0000;
    end else if (i_sample_valid) begin
      // (RQ5) alarm set below trip
      // (RQ8) alarm cleared above trip
      underspeed  <= next_under;
      overspeed   <= next_over;
      underexcite <= next_unexc;
      // (RQ13) switch to working slope
      started     <= started | (freq > us_thr);
      eff_us      <= us_val;
      exc_value   <= i_sample.excite;
      sample_freq <= freq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Voltage reference with V/f drop and supply floor.
  // (RQ7) working slope
  // (RQ13) start-up slope before first pass
  wire logic [15:0] slope     = started ? working_vf_slope : startup_vf_slope;
  wire logic [15:0] shortfall = underspeed ? (us_thr - sample_freq) : 16'h0000;
  // The drop fraction is normalised to the trip point, so it scales for both modes.
  wire logic [31:0] rel       = ({16'h0000, shortfall} << 16) / {16'h0000, (us_thr == 16'h0000) ? 16'h0001 : us_thr};
  wire logic [47:0] frac_full = {16'h0000, rel} * {32'h0000_0000, slope};
  wire logic [47:0] frac      = frac_full >> fsvf_pkg::SLOPE_SHIFT;
  wire logic [16:0] frac_sat  = (frac > 48'h0000_0000_FFFF) ? 17'h10000 : {1'b0, frac[15:0]};
  wire logic [32:0] drop_full = {16'h0000, i_vref_nominal} * {16'h0000, frac_sat};
  wire logic [15:0] drop      = drop_full[31:16];
  wire logic [15:0] vf_ref    = i_vref_nominal - drop;
  // (RQ12) floor from supply ratio
  // A weaker auxiliary winding needs a higher regulated floor to stay fed.
  wire logic [31:0] floor_a   = ({16'h0000, i_vref_nominal} * {16'h0000, fsvf_pkg::FLOOR_NUM}) >> 8;
  wire logic [47:0] floor_b   = ({16'h0000, floor_a} * {32'h0000_0000, 16'h7FFF + {1'b0, supply_ratio_coeff[14:0]}})
                                / 48'h0000_0000_7FFF;
  wire logic [15:0] floor_v   = (floor_b > {32'h0000_0000, i_vref_nominal}) ? i_vref_nominal : floor_b[15:0];
  wire logic [15:0] next_vref = (vf_ref < floor_v) ? floor_v : vf_ref;

  ////////////////////////////////////////////////////////////////////////////////
  // Short-circuit timer.
  logic [31:0] tick_cnt;
  logic [7:0]  tenths;
  logic        blocked;
  wire logic   tick_end = tick_cnt == TENTH_CYCLES - 1;
  wire logic [7:0] sc_limit = short_circuit_time[7:0];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt <= 32'h0000_0000;
      tenths   <= 8'h00;
      blocked  <= 1'b0;
    end else if (!i_short_circuit) begin
      tick_cnt <= 32'h0000_0000;
      tenths   <= 8'h00;
    end else begin
      // (RQ14) count tenths, block at expiry
      tick_cnt <= tick_end ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
      if (tick_end && tenths != 8'hFF) begin
        tenths <= tenths + 8'h01;
      end
      // (RQ20) blocked sticks until reset
      if (sc_limit != 8'h00 && tenths >= sc_limit) begin
        blocked <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status, contact and readback.
  // (RQ18) one-hot alarms plus healthy bit
  wire logic [15:0] alarms = (16'(underspeed)     << fsvf_pkg::BIT_UNDERSPEED) |
                             (16'(overspeed)      << fsvf_pkg::BIT_OVERSPEED) |
                             (16'(underexcite)    << fsvf_pkg::BIT_UNDEREXC) |
                             (16'(i_short_circuit) << fsvf_pkg::BIT_SHORT);
  wire logic [15:0] next_status = alarms | (16'(alarms == 16'h0000) << fsvf_pkg::BIT_OK) |
                                  (16'(sixty) << fsvf_pkg::BIT_SIXTY);
  // (RQ17) contact only, no regulating action
  wire logic next_contact = i_alarm_contact_en & (alarms != 16'h0000);

  logic [15:0] next_rd;
  always_comb begin
    case (i_rd_addr)
      fsvf_pkg::ADDR_SUPPLY_RATIO:   next_rd = supply_ratio_coeff;
      fsvf_pkg::ADDR_UNDERSPEED:     next_rd = underspeed_threshold_param;
      fsvf_pkg::ADDR_WORK_SLOPE:     next_rd = working_vf_slope;
      fsvf_pkg::ADDR_START_SLOPE:    next_rd = startup_vf_slope;
      fsvf_pkg::ADDR_SC_TIME:        next_rd = short_circuit_time;
      fsvf_pkg::ADDR_OVERSPEED:      next_rd = overspeed_threshold_param;
      fsvf_pkg::ADDR_EXC_LOW:        next_rd = underexcite_low_limit;
      // (RQ6) effective threshold readable
      fsvf_pkg::ADDR_EFF_UNDERSPEED: next_rd = eff_us;
      fsvf_pkg::ADDR_STATUS:         next_rd = o_status;
      fsvf_pkg::ADDR_EXC_VALUE:      next_rd = exc_value;
      default:                       next_rd = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data              <= 16'h0000;
      o_vref                 <= 16'h0000;
      o_status               <= 16'h0800;
      o_blocked              <= 1'b0;
      o_alarm_output_contact <= 1'b0;
    end else begin
      o_rd_data              <= next_rd;
      // Blocked holds the reference at zero; the regulator stops driving excitation.
      o_vref                 <= blocked ? 16'h0000 : next_vref;
      o_status               <= next_status;
      o_blocked              <= blocked;
      o_alarm_output_contact <= next_contact;
    end
  end
endmodule : fsvf_top
`default_nettype wire

// [verilog/fsvf_pkg.sv]
// Purpose: Shared constants and types of the frequency protection block.
// Assumes: Frequencies are carried in hundredths of a hertz.
// Notes:   Register offsets are location indices on the parameter port.
package fsvf_pkg;
  localparam logic [7:0]  ADDR_SUPPLY_RATIO   = 8'h0E;
  localparam logic [7:0]  ADDR_UNDERSPEED     = 8'h15;
  localparam logic [7:0]  ADDR_WORK_SLOPE     = 8'h17;
  localparam logic [7:0]  ADDR_START_SLOPE    = 8'h18;
  localparam logic [7:0]  ADDR_SC_TIME        = 8'h19;
  localparam logic [7:0]  ADDR_OVERSPEED      = 8'h1A;
  localparam logic [7:0]  ADDR_EXC_LOW        = 8'h1B;
  localparam logic [7:0]  ADDR_EFF_UNDERSPEED = 8'h22;
  localparam logic [7:0]  ADDR_STATUS         = 8'h26;
  localparam logic [7:0]  ADDR_EXC_VALUE      = 8'h38;

  localparam logic [15:0] RST_SUPPLY_RATIO = 16'h0000;
  localparam logic [15:0] RST_UNDERSPEED   = 16'h6666;
  localparam logic [15:0] RST_WORK_SLOPE   = 16'h0753;
  localparam logic [15:0] RST_START_SLOPE  = 16'h04E2;
  localparam logic [15:0] RST_SC_TIME      = 16'h0000;
  localparam logic [15:0] RST_OVERSPEED    = 16'h0000;
  localparam logic [15:0] RST_EXC_LOW      = 16'h0000;

  // Fixed upper excitation limit; software has no path to change it.
  localparam logic [15:0] EXC_UPPER_LIMIT = 16'h7800;

  // Underspeed parameter knee and full scale.
  localparam logic [15:0] US_KNEE = 16'h6666;
  localparam logic [15:0] US_TOP_SPAN = 16'h1999;
  localparam logic [15:0] FULL_SCALE = 16'h7FFF;

  // Trip points in hundredths of a hertz: 50 Hz mode then 60 Hz mode.
  localparam logic [15:0] US_LOW_50  = 16'h0FA0;
  localparam logic [15:0] US_KNEE_50 = 16'h12C0;
  localparam logic [15:0] US_TOP_50  = 16'h1388;
  localparam logic [15:0] US_LOW_60  = 16'h12C0;
  localparam logic [15:0] US_KNEE_60 = 16'h1676;
  localparam logic [15:0] US_TOP_60  = 16'h1770;
  localparam logic [15:0] OS_MID_50  = 16'h157C;
  localparam logic [15:0] OS_SPAN_50 = 16'h01F4;
  localparam logic [15:0] OS_MID_60  = 16'h19C8;
  localparam logic [15:0] OS_SPAN_60 = 16'h0258;

  // Slope scaling: drop fraction is slope * relative_shortfall / 2^12.
  localparam int unsigned SLOPE_SHIFT = 12;
  // Voltage floor at direct phase supply, as a fraction of nominal over 256.
  localparam logic [15:0] FLOOR_NUM = 16'h0080;

  localparam int unsigned TENTH_S_NS = 100_000_000;
  localparam int unsigned CLK_NS     = 25;
  localparam int unsigned TENTH_S_CYC = TENTH_S_NS / CLK_NS;

  localparam int unsigned BIT_SHORT = 3;
  localparam int unsigned BIT_UNDERSPEED = 5;
  localparam int unsigned BIT_OVERSPEED = 6;
  localparam int unsigned BIT_UNDEREXC = 7;
  localparam int unsigned BIT_OK = 11;
  localparam int unsigned BIT_SIXTY = 15;

  typedef struct packed {
    logic [15:0] freq;
    logic [15:0] excite;
  } fsvf_sample_t;

  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] data;
  } fsvf_wr_t;
endpackage : fsvf_pkg

// [verilog/fsvf_lerp.sv]
// Purpose: Linear interpolation base + x * span / den on signed values.
// Assumes: den is nonzero; all operands fit 16 bits signed.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module fsvf_lerp #(
  parameter int W = 16
) (
  input  wire logic signed [W:0]   i_base,
  input  wire logic signed [W:0]   i_x,
  input  wire logic signed [W:0]   i_span,
  input  wire logic signed [W:0]   i_den,
  output logic signed      [W:0]   o_val
);
  if (W < 8) begin : g_bad_width
    $error("fsvf_lerp width too small");
  end
  wire logic signed [2*W+1:0] prod = i_x * i_span;
  wire logic signed [2*W+1:0] quot = prod / i_den;
  assign o_val = i_base + quot[W:0];
endmodule : fsvf_lerp
`default_nettype wire

// [sim/fsvf_props.sv]
// Purpose: Port assertions for the frequency protection block.
// Assumes: One clock domain; reset asynchronous and active low.
// Notes:   Status may lag the sample that causes it by one or two edges.
`timescale 1ns/1ps
`default_nettype none
module fsvf_props #(
  parameter int unsigned TENTH_CYCLES = 10
) (
  input wire logic                   i_clk,
  input wire logic                   i_rst_n,
  input wire logic                   i_sample_valid,
  input wire fsvf_pkg::fsvf_sample_t i_sample,
  input wire logic                   i_short_circuit,
  input wire logic                   i_alarm_contact_en,
  input wire logic [15:0]            o_vref,
  input wire logic [15:0]            o_status,
  input wire logic                   o_blocked,
  input wire logic                   o_alarm_output_contact
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  int unsigned sc_run;
  wire         any_alarm = |{o_status[7:5], o_status[3]};
  // Blocking can never come before a full tenth of continuous short.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) sc_run <= 0;
    else sc_run <= i_short_circuit ? sc_run + 1 : 0;
  end
  sequence blk_rise_s;
    !o_blocked ##1 o_blocked;
  endsequence
  sequence sample_s(logic c);
    i_sample_valid && c;
  endsequence
  ok_bit_a: assert property (o_status[11] == !any_alarm)
    else $error("healthy bit disagrees with alarm bits");
  us_floor_a: assert property (sample_s(i_sample.freq < fsvf_pkg::US_LOW_50) |-> ##[1:2] o_status[5])
    else $error("low frequency without underspeed flag");
  os_ceiling_a: assert property (sample_s(i_sample.freq > 16'h1C20) |-> ##[1:2] o_status[6])
    else $error("high frequency without overspeed flag");
  ue_upper_a: assert property (sample_s(i_sample.excite > fsvf_pkg::EXC_UPPER_LIMIT) |-> ##[1:2] o_status[7])
    else $error("excitation above upper limit not flagged");
  flag_cause_a: assert property ($changed(o_status[7:5]) |-> $past(i_sample_valid) || $past(i_sample_valid, 2))
    else $error("alarm flags changed without a sample");
  contact_off_a: assert property (!i_alarm_contact_en [*2] |-> !o_alarm_output_contact)
    else $error("contact closed while not configured");
  contact_on_a: assert property ((i_alarm_contact_en && any_alarm) [*3] |-> o_alarm_output_contact)
    else $error("contact open during configured alarm");
  blk_sticky_a: assert property (o_blocked |=> o_blocked)
    else $error("blocked state released without reset");
  blk_vref_a: assert property (o_blocked [*2] |-> o_vref == 16'h0000)
    else $error("voltage reference nonzero while blocked");
  sc_time_a: assert property (blk_rise_s |-> sc_run >= TENTH_CYCLES - 1)
    else $error("blocked before one tenth of short circuit");
endmodule : fsvf_props
bind fsvf_top fsvf_props #(.TENTH_CYCLES(TENTH_CYCLES)) props_u (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sample_valid(i_sample_valid), .i_sample(i_sample),
  .i_short_circuit(i_short_circuit), .i_alarm_contact_en(i_alarm_contact_en), .o_vref(o_vref),
  .o_status(o_status), .o_blocked(o_blocked), .o_alarm_output_contact(o_alarm_output_contact));
`default_nettype wire

// [sim/fsvf_meas_model.sv]
// Purpose: Frequency and excitation measurement path feeding the block.
// Assumes: A sample every i_period+1 cycles, launched on the falling edge.
// Notes:   Between samples the bus carries the inverse of the last one.
`timescale 1ns/1ps
`default_nettype none
module fsvf_meas_model (
  input  wire logic              i_clk,
  input  wire logic [15:0]       i_freq,
  input  wire logic [15:0]       i_excite,
  input  wire logic [3:0]        i_period,
  output logic                   o_valid,
  output fsvf_pkg::fsvf_sample_t o_sample
);
  logic [3:0]             cnt = 4'h0;
  fsvf_pkg::fsvf_sample_t last = '0;
  initial o_valid = 1'b0;
  initial o_sample = '0;
  // A stale value would let a block that ignores valid pass unseen.
  always @(negedge i_clk) begin
    o_valid <= (cnt >= i_period);
    o_sample <= (cnt >= i_period) ? {i_freq, i_excite} : ~last;
    if (cnt >= i_period) last <= {i_freq, i_excite};
    cnt <= (cnt >= i_period) ? 4'h0 : cnt + 4'h1;
  end
endmodule : fsvf_meas_model
`default_nettype wire

// [sim/testbench.sv]
// Purpose: Self-checking bench for the frequency protection block.
// Assumes: Inputs change on the falling edge; tenth of a second is 10 cycles.
// Notes:   Expected trips are worked out here in hundredths of a hertz.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned TC = 10;
  logic i_clk = 1'b0, i_rst_n = 1'b0, sv, trim_en = 1'b0, sc = 1'b0, con_en = 1'b0, blocked, contact;
  fsvf_pkg::fsvf_wr_t wr = '0;
  fsvf_pkg::fsvf_sample_t smp;
  logic [7:0]  rd_addr = 8'h00;
  logic [15:0] freq = 16'h03E8, exc = 16'h4000, nom = 16'h8000, trim = 16'h0000, rdata, vref, status;
  logic [3:0]  per = 4'h0;
  logic [2:0]  mode = 3'b000;
  int          n_mismatch = 0, n_checks = 0;
  logic [7:0]  ra[7] = '{8'h0E, 8'h15, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B};
  logic [15:0] rr[7] = '{16'h0000, 16'h6666, 16'h0753, 16'h04E2, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] pr[4] = '{16'h0000, 16'h3333, 16'h6666, 16'h7FFF};
  logic [15:0] ov[4] = '{16'h0000, 16'h8001, 16'h7FFF, 16'hC000};
  logic [15:0] ex[4] = '{16'h0FFF, 16'h1000, 16'h7800, 16'h7801};
  logic [2:0]  md[5] = '{3'b000, 3'b110, 3'b100, 3'b001, 3'b010};
  always #12.5 i_clk = ~i_clk;
  fsvf_meas_model meas_u (.i_clk(i_clk), .i_freq(freq), .i_excite(exc), .i_period(per), .o_valid(sv),
    .o_sample(smp));
  fsvf_top #(.TENTH_CYCLES(TC)) dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr(wr), .i_rd_addr(rd_addr),
    .i_sample_valid(sv), .i_sample(smp), .i_vref_nominal(nom), .i_frequency_trimmer_en(trim_en),
    .i_frequency_trimmer_input(trim), .i_jumper_closed(mode[2]), .i_jumper_use_en(mode[1]),
    .i_cfg_sixty_hz(mode[0]), .i_short_circuit(sc), .i_alarm_contact_en(con_en), .o_rd_data(rdata),
    .o_vref(vref), .o_status(status), .o_blocked(blocked), .o_alarm_output_contact(contact));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    wr = '{1'b1, a, d};
    @(negedge i_clk);
    wr.wr = 1'b0;
    @(negedge i_clk);
  endtask : wreg
  task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] e);
    rd_addr = a;
    @(negedge i_clk);
    chk(nm, rdata, e);
  endtask : rchk
  // Two samples make sure one was taken after the last input change.
  task automatic settle;
    int n, k;
    n = 0;
    for (k = 0; k < 40 && n < 2; k++) begin
      @(posedge i_clk);
      if (sv === 1'b1) n++;
    end
    if (n < 2) begin
      n_mismatch++;
      finish_test;
    end
    repeat (3) @(negedge i_clk);
  endtask : settle
  function automatic logic [15:0] us_trip(input int p, input bit s);
    int lo, kn, tp;
    lo = s ? 4800 : 4000;
    kn = s ? 5750 : 4800;
    tp = s ? 6000 : 5000;
    if (p <= 26214) return 16'(lo + p * (kn - lo) / 26214);
    return 16'(kn + (p - 26214) * (tp - kn) / 6553);
  endfunction : us_trip
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int k, p;
    bit s;
    logic [15:0] t;
    repeat (12) @(negedge i_clk);
    i_rst_n = 1'b1;
    @(negedge i_clk);
    for (k = 0; k < 7; k++) rchk("reset value", ra[k], rr[k]);
    rchk("eff reset", 8'h22, 16'h6666);
    rchk("unmapped", 8'h00, 16'h0000);
    wreg(8'h18, 16'h0000);
    wreg(8'h17, 16'hFFFF);
    settle;
    chk("vref startup", vref, nom);
    chk("status us", status, 16'h0020);
    freq = 16'h1388;
    settle;
    chk("status ok", status, 16'h0800);
    chk("vref ok", vref, nom);
    rchk("status rd", 8'h26, 16'h0800);
    freq = 16'h03E8;
    settle;
    chk("vref floor", vref, 16'h4000);
    wreg(8'h0E, 16'h7FFF);
    settle;
    chk("vref coeff", vref, nom);
    wreg(8'h0E, 16'h0000);
    wreg(8'h17, 16'h0000);
    settle;
    chk("vref slope0", vref, nom);
    wreg(8'h17, 16'h0753);
    settle;
    chk("vref drop", 16'(vref < nom && vref > 16'h4000), 16'h0001);
    for (k = 0; k < 5; k++) begin
      mode = md[k];
      s = (md[k][2] & md[k][1]) | md[k][0];
      for (p = 0; p < 4; p++) begin
        wreg(8'h15, pr[p]);
        t = us_trip(int'(pr[p]), s);
        freq = t - 16'h0001;
        settle;
        chk("us below", status, {s, 15'h0020});
        freq = t;
        settle;
        chk("us at", status, {s, 15'h0800});
      end
    end
    mode = 3'b000;
    trim_en = 1'b1;
    trim = 16'h2000;
    freq = 16'h1099;
    wreg(8'h22, 16'h1111);
    settle;
    rchk("eff trim", 8'h22, 16'h2000);
    chk("trim trip", status, 16'h0020);
    trim = 16'h9000;
    @(negedge i_clk);
    rchk("eff clamp", 8'h22, 16'h7FFF);
    trim_en = 1'b0;
    wreg(8'h15, 16'h0000);
    for (k = 0; k < 8; k++) begin
      s = k[2];
      mode = {2'b00, s};
      wreg(8'h1A, ov[k % 4]);
      t = 16'(s ? 6600 + int'($signed(ov[k % 4])) * 600 / 32767 : 5500 + int'($signed(ov[k % 4])) * 500 / 32767);
      freq = t;
      settle;
      chk("os at", status, {s, 15'h0800});
      freq = t + 16'h0001;
      settle;
      chk("os above", status, {s, 15'h0040});
    end
    mode = 3'b000;
    per = 4'h9;
    freq = 16'h1388;
    con_en = 1'b1;
    wreg(8'h1B, 16'h1000);
    for (k = 0; k < 4; k++) begin
      exc = ex[k];
      settle;
      s = (k == 0 || k == 3);
      chk("ue status", status, s ? 16'h0080 : 16'h0800);
      chk("ue contact", 16'(contact), 16'(s));
      chk("ue vref", vref, nom);
      rchk("exc value", 8'h38, ex[k]);
    end
    con_en = 1'b0;
    settle;
    chk("contact off", 16'(contact), 16'h0000);
    per = 4'h0;
    exc = 16'h4000;
    sc = 1'b1;
    repeat (300) @(negedge i_clk);
    chk("no block", 16'(blocked), 16'h0000);
    chk("short bit", status, 16'h0008);
    sc = 1'b0;
    wreg(8'h19, 16'h0003);
    sc = 1'b1;
    repeat (25) @(negedge i_clk);
    sc = 1'b0;
    @(negedge i_clk);
    sc = 1'b1;
    for (k = 0; k < 60 && blocked !== 1'b1; k++) @(negedge i_clk);
    chk("block time", 16'(k >= 28 && k <= 34), 16'h0001);
    sc = 1'b0;
    settle;
    chk("block hold", 16'({blocked, vref == 16'h0000}), 16'h0003);
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_clk);
    i_rst_n = 1'b1;
    @(negedge i_clk);
    chk("block reset", 16'(blocked), 16'h0000);
    finish_test;
  end
endmodule : testbench
`default_nettype wire
